// *** rtl/dmce_consts.vh ***
`ifndef DMCE_CONSTS_VH
`define DMCE_CONSTS_VH
// ************************************************
// command bytes received from the host
// ************************************************
`define DMCE_OP_NOP 8'h20
`define DMCE_OP_REGMAP 8'h21
`define DMCE_OP_RDMEM 8'h22
`define DMCE_OP_STACK 8'h23
`define DMCE_OP_WRREG 8'h24
`define DMCE_OP_WRMEM 8'h25
`define DMCE_OP_TRACE 8'h26
`define DMCE_OP_RETURN 8'h27
`define DMCE_OP_UNLOCK 8'h28
`define DMCE_OP_RDREG 8'h29
// ************************************************
// command codes handed to the service routine
// ************************************************
`define DMCE_CMD_NONE 4'h0
`define DMCE_CMD_REGMAP 4'h1
`define DMCE_CMD_RDMEM 4'h2
`define DMCE_CMD_STACK 4'h3
`define DMCE_CMD_WRREG 4'h4
`define DMCE_CMD_WRMEM 4'h5
`define DMCE_CMD_UNLOCK 4'h8
`define DMCE_CMD_RDREG 4'h9
// ************************************************
// shift-register status codes and vector
// ************************************************
`define DMCE_ST_NONDBG 2'h0
`define DMCE_ST_IDLE 2'h1
`define DMCE_ST_BUSY 2'h2
`define DMCE_ST_VALID 2'h3
`define DMCE_ROM_VECTOR 16'h8010
// ************************************************
// follow-on byte counts
// ************************************************
`define DMCE_CNT_ZERO 6'h00
`define DMCE_CNT_ONE 6'h01
`define DMCE_CNT_TWO 6'h02
`define DMCE_CNT_FOUR 6'h04
`define DMCE_CNT_PWD 6'h20
// ************************************************
// byte positions within a four byte stream
// ************************************************
`define DMCE_POS_B0 2'h0
`define DMCE_POS_B1 2'h1
`define DMCE_POS_B2 2'h2
`define DMCE_POS_B3 2'h3
`endif

// *** rtl/dmce_engine.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dmce_consts.vh"
module dmce_engine (
  input wire SYS_CLK,
  input wire RST,
  input wire DBG_ENTER,
  input wire IGE_AT_ENTRY,
  input wire SWITCHBACK_ENABLE,
  input wire LOW_POWER_CLOCK_MODE,
  input wire RX_VALID,
  input wire [7:0] RX_BYTE,
  output reg RX_READY,
  output reg TX_VALID,
  output reg [7:0] TX_BYTE,
  input wire TX_READY,
  input wire ROM_LOAD,
  input wire [7:0] ROM_BYTE,
  input wire ROM_DONE_FLAG,
  input wire STEP_DONE,
  output reg [15:0] DEBUG_ADDRESS_HOLDING,
  output reg [15:0] DEBUG_DATA_HOLDING,
  output reg [7:0] DEBUG_BYTE_BUFFER,
  output reg [3:0] DEBUG_CONTROL_REG,
  output reg TRANSFER_COMPLETE_FLAG,
  output reg ROM_DONE_CLEAR,
  output reg [1:0] STATUS,
  output reg ROM_ENABLE,
  output reg JUMP_ROM,
  output reg [15:0] JUMP_ADDR,
  output reg STACK_POP,
  output reg STACK_PUSH,
  output reg GLOBAL_INTERRUPT_ENABLE,
  output reg IGE_OVERRIDE,
  output reg CPU_HALT,
  output reg CPU_RUN_ONE,
  output reg FETCH_BLOCK,
  output reg BREAK_SUPPRESS,
  output reg TIMER_CLK_EN,
  output reg CLOCK_SWITCHBACK
);
  // ************************************************
  // engine states
  // ************************************************
  localparam S_BG = 7'h01;
  localparam S_IDLE = 7'h02;
  localparam S_COLLECT = 7'h04;
  localparam S_ROM = 7'h08;
  localparam S_STEP = 7'h10;
  localparam S_REENTER = 7'h20;
  localparam S_RET = 7'h40;

  reg [6:0] state_r;
  reg [7:0] op_r;
  reg [5:0] need_r;
  reg [5:0] got_r;
  reg [1:0] pos_r;
  reg ige_entry_r;
  // two-entry skid buffer in the receive path
  reg [7:0] buf_data_r [0:1];
  reg [1:0] buf_cnt_r;
  reg buf_wp_r;
  reg buf_rp_r;
  wire buf_take;
  wire buf_push;
  wire [7:0] head_byte;

  // follow-on byte count for a command; unknown codes need none
  function [5:0] follow_count;
    input [7:0] op;
    begin
      case (op)
        `DMCE_OP_RDMEM: follow_count = `DMCE_CNT_FOUR;
        `DMCE_OP_STACK: follow_count = `DMCE_CNT_FOUR;
        `DMCE_OP_WRREG: follow_count = `DMCE_CNT_FOUR;
        `DMCE_OP_WRMEM: follow_count = `DMCE_CNT_FOUR;
        `DMCE_OP_UNLOCK: follow_count = `DMCE_CNT_PWD;
        `DMCE_OP_RDREG: follow_count = `DMCE_CNT_TWO;
        default: follow_count = `DMCE_CNT_ZERO;
      endcase
    end
  endfunction

  // code handed to the service routine
  function [3:0] cmd_code;
    input [7:0] op;
    begin
      case (op)
        `DMCE_OP_REGMAP: cmd_code = `DMCE_CMD_REGMAP;
        `DMCE_OP_RDMEM: cmd_code = `DMCE_CMD_RDMEM;
        `DMCE_OP_STACK: cmd_code = `DMCE_CMD_STACK;
        `DMCE_OP_WRREG: cmd_code = `DMCE_CMD_WRREG;
        `DMCE_OP_WRMEM: cmd_code = `DMCE_CMD_WRMEM;
        `DMCE_OP_UNLOCK: cmd_code = `DMCE_CMD_UNLOCK;
        `DMCE_OP_RDREG: cmd_code = `DMCE_CMD_RDREG;
        default: cmd_code = `DMCE_CMD_NONE;
      endcase
    end
  endfunction

  // ************************************************
  // receive buffer
  // ************************************************
  // engine only drains bytes while idle or collecting, so the host stalls
  assign head_byte = buf_data_r[buf_rp_r];
  assign buf_push = RX_VALID && RX_READY;
  assign buf_take = (buf_cnt_r != 2'h0) && ((state_r == S_IDLE) || (state_r == S_COLLECT));
  always @(posedge SYS_CLK) begin
    if (RST) begin
      buf_cnt_r <= 2'h0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      RX_READY <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_data_r[buf_wp_r] <= RX_BYTE;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_take)
        buf_rp_r <= ~buf_rp_r;
      case ({buf_push, buf_take})
        2'h2: buf_cnt_r <= buf_cnt_r + 2'h1;
        2'h1: buf_cnt_r <= buf_cnt_r - 2'h1;
        default: buf_cnt_r <= buf_cnt_r;
      endcase
      // registered ready: free room after this cycle's push and pop
      RX_READY <= ((buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_take}) < 2'h2)
        && (state_r != S_BG);
    end
  end

  // ************************************************
  // transmit path for register map and register read bytes
  // ************************************************
  always @(posedge SYS_CLK) begin
    if (RST) begin
      TX_VALID <= 1'b0;
      TX_BYTE <= 8'h00;
      TRANSFER_COMPLETE_FLAG <= 1'b0;
      DEBUG_BYTE_BUFFER <= 8'h00;
    end else begin
      // a load in the same cycle as the transfer end wins for the flag; for TX_VALID the transfer end wins and the byte is lost
      if (ROM_LOAD) begin
        DEBUG_BYTE_BUFFER <= ROM_BYTE;
        TRANSFER_COMPLETE_FLAG <= 1'b1;
      end else if (TX_VALID && TX_READY) begin
        TRANSFER_COMPLETE_FLAG <= 1'b0;
      end else if (buf_take && (state_r == S_COLLECT) && (op_r == `DMCE_OP_UNLOCK)) begin
        DEBUG_BYTE_BUFFER <= head_byte;
      end
      if (TX_VALID && TX_READY)
        TX_VALID <= 1'b0;
      else if (ROM_LOAD && (state_r == S_ROM)) begin
        TX_VALID <= 1'b1;
        TX_BYTE <= ROM_BYTE;
      end
    end
  end

  // ************************************************
  // command engine
  // ************************************************
  always @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= S_BG;
      op_r <= `DMCE_OP_NOP;
      need_r <= `DMCE_CNT_ZERO;
      got_r <= `DMCE_CNT_ZERO;
      pos_r <= `DMCE_POS_B0;
      ige_entry_r <= 1'b0;
      DEBUG_ADDRESS_HOLDING <= 16'h0000;
      DEBUG_DATA_HOLDING <= 16'h0000;
      DEBUG_CONTROL_REG <= `DMCE_CMD_NONE;
      ROM_DONE_CLEAR <= 1'b0;
      STATUS <= `DMCE_ST_NONDBG;
      ROM_ENABLE <= 1'b0;
      JUMP_ROM <= 1'b0;
      JUMP_ADDR <= 16'h0000;
      STACK_POP <= 1'b0;
      STACK_PUSH <= 1'b0;
      GLOBAL_INTERRUPT_ENABLE <= 1'b0;
      IGE_OVERRIDE <= 1'b0;
      CPU_HALT <= 1'b0;
      CPU_RUN_ONE <= 1'b0;
      FETCH_BLOCK <= 1'b0;
      BREAK_SUPPRESS <= 1'b0;
      TIMER_CLK_EN <= 1'b1;
      CLOCK_SWITCHBACK <= 1'b0;
    end else begin
      // one-cycle strobes default low
      JUMP_ROM <= 1'b0;
      STACK_POP <= 1'b0;
      STACK_PUSH <= 1'b0;
      CPU_RUN_ONE <= 1'b0;
      ROM_DONE_CLEAR <= 1'b0;
      BREAK_SUPPRESS <= 1'b0;
      case (state_r)
        S_BG: begin
          if (DBG_ENTER) begin
            // entry push may overwrite the oldest slot when the stack is full
            STACK_PUSH <= 1'b1;
            ige_entry_r <= IGE_AT_ENTRY;
            GLOBAL_INTERRUPT_ENABLE <= 1'b0;
            CPU_HALT <= 1'b1;
            TIMER_CLK_EN <= 1'b0;
            CLOCK_SWITCHBACK <= SWITCHBACK_ENABLE && LOW_POWER_CLOCK_MODE;
            STATUS <= `DMCE_ST_IDLE;
            state_r <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (buf_take) begin
            op_r <= head_byte;
            need_r <= follow_count(head_byte);
            got_r <= `DMCE_CNT_ZERO;
            pos_r <= `DMCE_POS_B0;
            if (head_byte == `DMCE_OP_TRACE) begin
              STATUS <= `DMCE_ST_BUSY;
              STACK_POP <= 1'b1;
              GLOBAL_INTERRUPT_ENABLE <= ige_entry_r;
              IGE_OVERRIDE <= 1'b1;
              CPU_HALT <= 1'b0;
              CPU_RUN_ONE <= 1'b1;
              state_r <= S_STEP;
            end else if (head_byte == `DMCE_OP_RETURN) begin
              STACK_POP <= 1'b1;
              GLOBAL_INTERRUPT_ENABLE <= ige_entry_r;
              state_r <= S_RET;
            end else if (head_byte == `DMCE_OP_REGMAP) begin
              DEBUG_CONTROL_REG <= cmd_code(head_byte);
              ROM_ENABLE <= 1'b1;
              JUMP_ROM <= 1'b1;
              JUMP_ADDR <= `DMCE_ROM_VECTOR;
              STATUS <= `DMCE_ST_VALID;
              state_r <= S_ROM;
            end else if (follow_count(head_byte) != `DMCE_CNT_ZERO) begin
              state_r <= S_COLLECT;
              if (head_byte == `DMCE_OP_UNLOCK) begin
                // unlock vectors at once and feeds bytes as they arrive
                DEBUG_CONTROL_REG <= `DMCE_CMD_UNLOCK;
                ROM_ENABLE <= 1'b1;
                JUMP_ROM <= 1'b1;
                JUMP_ADDR <= `DMCE_ROM_VECTOR;
                STATUS <= `DMCE_ST_BUSY;
              end
            end
            // other encodings are dropped and status stays idle
          end
        end
        S_COLLECT: begin
          if (buf_take) begin
            pos_r <= pos_r + 2'h1;
            got_r <= got_r + `DMCE_CNT_ONE;
            // address low, address high, then count or data low, high
            case (pos_r)
              `DMCE_POS_B0: DEBUG_ADDRESS_HOLDING[7:0] <= head_byte;
              `DMCE_POS_B1: DEBUG_ADDRESS_HOLDING[15:8] <= head_byte;
              `DMCE_POS_B2: DEBUG_DATA_HOLDING[7:0] <= head_byte;
              `DMCE_POS_B3: DEBUG_DATA_HOLDING[15:8] <= head_byte;
              default: DEBUG_ADDRESS_HOLDING <= DEBUG_ADDRESS_HOLDING;
            endcase
            // wait for the full count; there is no timeout
            if (got_r + `DMCE_CNT_ONE == need_r) begin
              state_r <= S_ROM;
              if (op_r != `DMCE_OP_UNLOCK) begin
                DEBUG_CONTROL_REG <= cmd_code(op_r);
                ROM_ENABLE <= 1'b1;
                JUMP_ROM <= 1'b1;
                JUMP_ADDR <= `DMCE_ROM_VECTOR;
                STATUS <= (op_r == `DMCE_OP_RDREG) ? `DMCE_ST_VALID : `DMCE_ST_BUSY;
              end
            end
          end
        end
        S_ROM: begin
          // routine reports done; engine acknowledges and goes idle
          if (ROM_DONE_FLAG && !TX_VALID && !ROM_DONE_CLEAR) begin
            ROM_DONE_CLEAR <= 1'b1;
            DEBUG_CONTROL_REG <= `DMCE_CMD_NONE;
            STATUS <= `DMCE_ST_IDLE;
            state_r <= S_IDLE;
          end
        end
        S_STEP: begin
          if (STEP_DONE) begin
            FETCH_BLOCK <= 1'b1;
            CPU_HALT <= 1'b1;
            STACK_PUSH <= 1'b1;
            JUMP_ROM <= 1'b1;
            JUMP_ADDR <= `DMCE_ROM_VECTOR;
            GLOBAL_INTERRUPT_ENABLE <= 1'b0;
            state_r <= S_REENTER;
          end
        end
        S_REENTER: begin
          FETCH_BLOCK <= 1'b0;
          IGE_OVERRIDE <= 1'b0;
          STATUS <= `DMCE_ST_IDLE;
          state_r <= S_IDLE;
        end
        S_RET: begin
          // ige was restored on the pop cycle; now release the cpu
          CPU_HALT <= 1'b0;
          ROM_ENABLE <= 1'b0;
          TIMER_CLK_EN <= 1'b1;
          BREAK_SUPPRESS <= 1'b1;
          CLOCK_SWITCHBACK <= 1'b0;
          STATUS <= `DMCE_ST_NONDBG;
          state_r <= S_BG;
        end
        default: state_r <= S_BG;
      endcase
    end
  end
endmodule // dmce_engine
`default_nettype wire

// *** sim/dmce_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker for the debug engine
// ****
module dmce_chk (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic ROM_LOAD,
  input wire logic ROM_DONE_FLAG,
  input wire logic STEP_DONE,
  input wire logic TRANSFER_COMPLETE_FLAG,
  input wire logic ROM_DONE_CLEAR,
  input wire logic [1:0] STATUS,
  input wire logic JUMP_ROM,
  input wire logic [15:0] JUMP_ADDR,
  input wire logic STACK_POP,
  input wire logic STACK_PUSH,
  input wire logic IGE_OVERRIDE,
  input wire logic CPU_HALT,
  input wire logic CPU_RUN_ONE,
  input wire logic BREAK_SUPPRESS,
  input wire logic TIMER_CLK_EN
);
  // one clock domain, so one clocking and one disable for all
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_reset_idle: assert property ($fell(RST) |-> STATUS == 2'h0 && TIMER_CLK_EN)
    else $error("engine not idle after reset");
  a_jump_vector: assert property (JUMP_ROM |-> JUMP_ADDR == 16'h8010 && STATUS[1])
    else $error("bad routine vector");
  a_flag_set: assert property (ROM_LOAD |=> TRANSFER_COMPLETE_FLAG)
    else $error("transfer flag not set");
  a_flag_clear: assert property (TX_VALID && TX_READY && !ROM_LOAD |=> !TRANSFER_COMPLETE_FLAG)
    else $error("transfer flag not cleared");
  a_valid_tag: assert property (TX_VALID |-> STATUS == 2'h3)
    else $error("output byte without valid status");
  a_trace_start: assert property (CPU_RUN_ONE |-> STACK_POP && STATUS == 2'h2 && !CPU_HALT)
    else $error("step start wrong");
  a_trace_end: assert property (STEP_DONE && IGE_OVERRIDE |=>
    STACK_PUSH && JUMP_ROM && CPU_HALT ##1 STATUS == 2'h1)
    else $error("step re-entry wrong");
  a_return_end: assert property (STACK_POP && !CPU_RUN_ONE |=>
    STATUS == 2'h0 && BREAK_SUPPRESS && TIMER_CLK_EN && !CPU_HALT)
    else $error("return sequence wrong");
  a_done_ack: assert property (ROM_DONE_FLAG && STATUS == 2'h2 && !IGE_OVERRIDE |=>
    ROM_DONE_CLEAR && STATUS == 2'h1)
    else $error("routine done not acknowledged");
endmodule // dmce_chk
bind dmce_engine dmce_chk i_dmce_chk (.SYS_CLK(SYS_CLK), .RST(RST), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .ROM_LOAD(ROM_LOAD), .ROM_DONE_FLAG(ROM_DONE_FLAG),
  .STEP_DONE(STEP_DONE), .TRANSFER_COMPLETE_FLAG(TRANSFER_COMPLETE_FLAG),
  .ROM_DONE_CLEAR(ROM_DONE_CLEAR), .STATUS(STATUS), .JUMP_ROM(JUMP_ROM), .JUMP_ADDR(JUMP_ADDR),
  .STACK_POP(STACK_POP), .STACK_PUSH(STACK_PUSH), .IGE_OVERRIDE(IGE_OVERRIDE),
  .CPU_HALT(CPU_HALT), .CPU_RUN_ONE(CPU_RUN_ONE), .BREAK_SUPPRESS(BREAK_SUPPRESS),
  .TIMER_CLK_EN(TIMER_CLK_EN));
`default_nettype wire

// *** sim/dmce_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// debug host model on the byte streams
// ****
module dmce_host (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  input wire logic stall
);
  logic [7:0] out_q[$];
  logic [7:0] got_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // byte held until taken; idle data toggles so stale values never pass
  // pacing is set by the bench, single clock here only user code is stepped
  always @(posedge clk) begin
    if (!rx_valid || rx_ready) begin
      if (out_q.size() != 0) begin
        rx_valid <= 1'b1;
        rx_byte <= out_q.pop_front();
      end else begin
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end
    end
    if (tx_valid && tx_ready) got_q.push_back(tx_byte);
    tx_ready <= !stall;
  end
endmodule // dmce_host
`default_nettype wire

// *** sim/test_debug_mode_command_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_debug_mode_command_engine;
  logic SYS_CLK, RST, DBG_ENTER, IGE_AT_ENTRY, SWITCHBACK_ENABLE, LOW_POWER_CLOCK_MODE;
  logic RX_VALID, RX_READY, TX_VALID, TX_READY, ROM_LOAD, ROM_DONE_FLAG, STEP_DONE, stall;
  logic [7:0] RX_BYTE, TX_BYTE, ROM_BYTE, DEBUG_BYTE_BUFFER;
  logic [15:0] DEBUG_ADDRESS_HOLDING, DEBUG_DATA_HOLDING, JUMP_ADDR;
  logic [3:0] DEBUG_CONTROL_REG;
  logic [1:0] STATUS;
  logic TRANSFER_COMPLETE_FLAG, ROM_DONE_CLEAR, ROM_ENABLE, JUMP_ROM, STACK_POP, STACK_PUSH;
  logic GLOBAL_INTERRUPT_ENABLE, IGE_OVERRIDE, CPU_HALT, CPU_RUN_ONE, FETCH_BLOCK;
  logic BREAK_SUPPRESS, TIMER_CLK_EN, CLOCK_SWITCHBACK;
  int fails, comparisons, cycles, n;
  dmce_engine i_dmce_engine (.SYS_CLK(SYS_CLK), .RST(RST), .DBG_ENTER(DBG_ENTER),
    .IGE_AT_ENTRY(IGE_AT_ENTRY), .SWITCHBACK_ENABLE(SWITCHBACK_ENABLE),
    .LOW_POWER_CLOCK_MODE(LOW_POWER_CLOCK_MODE), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .TX_READY(TX_READY),
    .ROM_LOAD(ROM_LOAD), .ROM_BYTE(ROM_BYTE), .ROM_DONE_FLAG(ROM_DONE_FLAG),
    .STEP_DONE(STEP_DONE), .DEBUG_ADDRESS_HOLDING(DEBUG_ADDRESS_HOLDING),
    .DEBUG_DATA_HOLDING(DEBUG_DATA_HOLDING), .DEBUG_BYTE_BUFFER(DEBUG_BYTE_BUFFER),
    .DEBUG_CONTROL_REG(DEBUG_CONTROL_REG), .TRANSFER_COMPLETE_FLAG(TRANSFER_COMPLETE_FLAG),
    .ROM_DONE_CLEAR(ROM_DONE_CLEAR), .STATUS(STATUS), .ROM_ENABLE(ROM_ENABLE),
    .JUMP_ROM(JUMP_ROM), .JUMP_ADDR(JUMP_ADDR), .STACK_POP(STACK_POP), .STACK_PUSH(STACK_PUSH),
    .GLOBAL_INTERRUPT_ENABLE(GLOBAL_INTERRUPT_ENABLE), .IGE_OVERRIDE(IGE_OVERRIDE),
    .CPU_HALT(CPU_HALT), .CPU_RUN_ONE(CPU_RUN_ONE), .FETCH_BLOCK(FETCH_BLOCK),
    .BREAK_SUPPRESS(BREAK_SUPPRESS), .TIMER_CLK_EN(TIMER_CLK_EN),
    .CLOCK_SWITCHBACK(CLOCK_SWITCHBACK));
  dmce_host i_dmce_host (.clk(SYS_CLK), .rx_ready(RX_READY), .rx_valid(RX_VALID),
    .rx_byte(RX_BYTE), .tx_valid(TX_VALID), .tx_byte(TX_BYTE), .tx_ready(TX_READY),
    .stall(stall));
  // ****
  // shared helpers
  // ****
  always #50 SYS_CLK = ~SYS_CLK;
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // a hang is cut short well above the longest expected run
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results;
    end
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic send(input logic [7:0] b);
    i_dmce_host.out_q.push_back(b);
  endtask
  // wait until the host has handed over every queued byte
  task automatic wait_sent;
    for (n = 0; n < 300 && (RX_VALID === 1'b1 || i_dmce_host.out_q.size() != 0); n++)
      @(negedge SYS_CLK);
  endtask
  task automatic wait_st(input logic [1:0] s);
    for (n = 0; n < 300 && STATUS !== s; n++) @(negedge SYS_CLK);
    chk(STATUS === s, "status not reached");
  endtask
  task automatic rom_done;
    @(posedge SYS_CLK) ROM_DONE_FLAG <= 1'b1;
    for (n = 0; n < 50 && ROM_DONE_CLEAR !== 1'b1; n++) @(negedge SYS_CLK);
    @(posedge SYS_CLK) ROM_DONE_FLAG <= 1'b0;
    wait_st(2'h1);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_enter(input logic sw);
    @(posedge SYS_CLK) DBG_ENTER <= 1'b1;
    @(posedge SYS_CLK) DBG_ENTER <= 1'b0;
    wait_st(2'h1);
    chk(CLOCK_SWITCHBACK === sw, "switchback wrong");
    chk(TIMER_CLK_EN === 1'b0, "timers still run");
  endtask
  // four follow bytes; last one held back to prove nothing acts early
  task automatic t_four(input logic [7:0] op, input logic [3:0] code);
    send(op); send(8'h34); send(8'h12); send(8'hCD);
    wait_sent;
    repeat (4) @(negedge SYS_CLK);
    chk(STATUS === 2'h1, "acted before last byte");
    send(8'hAB);
    wait_st(2'h2);
    chk(DEBUG_ADDRESS_HOLDING === 16'h1234, "address");
    chk(DEBUG_DATA_HOLDING === 16'hABCD && DEBUG_CONTROL_REG === code, "data or code");
    chk(ROM_ENABLE === 1'b1 && JUMP_ADDR === 16'h8010, "routine not enabled");
    send(8'h20); send(8'h2F); send(8'h20);
    repeat (10) @(negedge SYS_CLK);
    chk(RX_READY === 1'b0, "buffer took a third byte while busy");
    rom_done;
    wait_sent;
    repeat (4) @(negedge SYS_CLK);
    chk(STATUS === 2'h1 && DEBUG_CONTROL_REG === 4'h0, "no-op acted");
  endtask
  // routine answers nb bytes; the host stalls on the first one
  task automatic t_out(input logic [7:0] op, input int nf, input logic [3:0] code, input int nb);
    send(op);
    for (int i = 0; i < nf; i++) send(i == 0 ? 8'h34 : 8'h12);
    wait_st(2'h3);
    chk(DEBUG_CONTROL_REG === code, "command code");
    if (nf == 2) chk(DEBUG_ADDRESS_HOLDING === 16'h1234, "read address");
    for (int i = 0; i < nb; i++) begin
      @(posedge SYS_CLK) ROM_LOAD <= 1'b1;
      ROM_BYTE <= 8'hA0 + i[7:0];
      stall <= (i == 0);
      @(posedge SYS_CLK) ROM_LOAD <= 1'b0;
      repeat (5) @(posedge SYS_CLK);
      stall <= 1'b0;
      for (n = 0; n < 50 && TRANSFER_COMPLETE_FLAG !== 1'b0; n++) @(negedge SYS_CLK);
      chk(TRANSFER_COMPLETE_FLAG === 1'b0, "flag not cleared");
    end
    chk(i_dmce_host.got_q.size() == nb, "byte count");
    for (int i = 0; i < nb; i++) chk(i_dmce_host.got_q[i] === 8'hA0 + i[7:0], "byte");
    i_dmce_host.got_q.delete();
    rom_done;
  endtask
  task automatic t_unlock;
    send(8'h28);
    for (int i = 0; i < 32; i++) send(8'h40 + i[7:0]);
    wait_sent;
    repeat (4) @(negedge SYS_CLK);
    chk(DEBUG_BYTE_BUFFER === 8'h5F && DEBUG_CONTROL_REG === 4'h8, "unlock");
    chk(STATUS === 2'h2, "unlock status");
    rom_done;
  endtask
  task automatic t_trace;
    send(8'h26);
    wait_st(2'h2);
    chk(GLOBAL_INTERRUPT_ENABLE === 1'b1 && IGE_OVERRIDE === 1'b1, "step enable");
    @(posedge SYS_CLK) STEP_DONE <= 1'b1;
    @(posedge SYS_CLK) STEP_DONE <= 1'b0;
    @(negedge SYS_CLK);
    chk(FETCH_BLOCK === 1'b1, "next fetch not blocked");
    wait_st(2'h1);
    chk(CPU_HALT === 1'b1 && GLOBAL_INTERRUPT_ENABLE === 1'b0, "not halted");
  endtask
  task automatic t_return;
    send(8'h27);
    wait_st(2'h0);
    chk(TIMER_CLK_EN === 1'b1 && CPU_HALT === 1'b0, "not resumed");
    chk(GLOBAL_INTERRUPT_ENABLE === 1'b1, "enable not restored");
    chk(ROM_ENABLE === 1'b0, "routine still enabled");
  endtask
  // reset in mid-command drops the engine back to background
  task automatic t_reset_mid;
    // full speed clock this time, so no switchback may be forced
    @(posedge SYS_CLK) LOW_POWER_CLOCK_MODE <= 1'b0;
    t_enter(1'b0);
    send(8'h24); send(8'h01);
    wait_sent;
    @(posedge SYS_CLK) RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(negedge SYS_CLK);
    chk(STATUS === 2'h0 && TIMER_CLK_EN === 1'b1, "reset");
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    SYS_CLK = 1'b0; RST = 1'b1; DBG_ENTER = 1'b0; IGE_AT_ENTRY = 1'b1;
    SWITCHBACK_ENABLE = 1'b1; LOW_POWER_CLOCK_MODE = 1'b1; ROM_LOAD = 1'b0;
    ROM_BYTE = 8'h00; ROM_DONE_FLAG = 1'b0; STEP_DONE = 1'b0; stall = 1'b0;
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_enter(1'b1);
    t_four(8'h23, 4'h3);
    t_four(8'h24, 4'h4);
    t_four(8'h25, 4'h5);
    t_four(8'h22, 4'h2);
    t_out(8'h29, 2, 4'h9, 2);
    t_out(8'h21, 0, 4'h1, 3);
    t_unlock;
    t_trace;
    t_return;
    t_reset_mid;
    results;
  end
endmodule // test_debug_mode_command_engine
`default_nettype wire
